/* File: verilog/gpio_sense_port.sv */
// Sensing GPIO port with capture flags, hit routing and split security
`timescale 1ns/1ns

// How it works
// - Thirty-two pins, each with own pad_config
// - pad_config sets direction, drive, pull, sense, buffer
// - Disconnected buffer: input reads zero, sense blind
// - Peripherals override output, direction; read input
// - Pad level reaches input register in two cycles
// - Per-pin level_hit while input matches sense level, once re-armed by three cycles off it
// - Default mode ORs each security domain's pin hits together
// - Sensing works in running and system-off
// - Level already present hits at once on enable
// - Port hit also drives wake and event unit
// - Rising hit sets capture flag of that pin
// - Flag clears by writing one, hit low
// - Falling hit never clears a flag
// - Each domain's captured_hit high while any of its flags set, low one cycle on a clear write
// - Flags left after clear give fresh rise
// - Capture flags readable at any time
// - hit_source_select picks captured_hit over direct hits
// - Non-secure access touches only non-secure pins
// - Dropped secure-pin accesses raise no error
// - Secure bits in port registers: ignored, read zero
// - secure_hit_source_select only for secure access
// - Two select bits steer two port hit outputs
// - Select zero direct hits, one captured_hit
module gpio_sense_port
  import gpio_sense_pkg::*;
#(
  parameter int PINS = NUM_PINS
)
(
  input  wire logic                i_ref_clk,
  input  wire logic                i_srst,
  input  wire reg_req_t            i_req,
  output logic        [DATA_W-1:0] o_rdata,
  input  wire logic   [PINS-1:0]   i_pad_in,
  input  wire logic   [PINS-1:0]   i_pad_security_map,
  input  wire logic   [PINS-1:0]   i_periph_own,
  input  wire logic   [PINS-1:0]   i_periph_out,
  input  wire logic   [PINS-1:0]   i_periph_oe,
  input  wire logic   [PINS-1:0]   i_periph_in_req,
  output pad_ctrl_t                o_pad_ctrl,
  output logic        [3*PINS-1:0] o_pad_drive,
  output logic        [PINS-1:0]   o_periph_in,
  output logic        [PINS-1:0]   o_level_hit,
  output logic                     o_nonsecure_port_hit,
  output logic                     o_secure_port_hit,
  output logic                     o_captured_hit_ns,
  output logic                     o_captured_hit_s,
  output logic                     o_wake
);

  // ****************************************************************
  // State
  // ****************************************************************
  pad_cfg_t            cfg_q      [PINS];
  pad_cfg_t            cfg_d      [PINS];
  logic   [PINS-1:0]   out_q,     out_d;
  logic   [PINS-1:0]   dir_q,     dir_d;
  logic   [PINS-1:0]   flag_q,    flag_d;
  logic   [PINS-1:0]   hit_q,     hit_d;
  logic   [1:0]        rest_q     [PINS];
  logic   [1:0]        rest_d     [PINS];
  logic   [PINS-1:0]   samp1_q,   samp1_d;
  logic   [PINS-1:0]   in_q;
  logic                src_ns_q,  src_ns_d;
  logic                src_s_q,   src_s_d;
  logic                cap_ns_q,  cap_ns_d;
  logic                cap_s_q,   cap_s_d;
  logic                hit_ns_q,  hit_ns_d;
  logic                hit_s_q,   hit_s_d;
  logic                wake_q,    wake_d;
  logic   [DATA_W-1:0] rdata_q,   rdata_d;
  pad_ctrl_t           pad_q,     pad_d;
  logic   [3*PINS-1:0] drive_q,   drive_d;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic   [PINS-1:0]   acc_mask;
  logic   [PINS-1:0]   wbits;
  logic                cfg_hit;
  logic   [4:0]        cfg_idx;
  logic                cap_clr_wr;
  logic   [PINS-1:0]   in_en;
  logic   [PINS-1:0]   raw;

  // Non-secure accesses see only pins the map leaves non-secure
  assign acc_mask   = i_req.secure ? {PINS{1'b1}} : ~i_pad_security_map;
  assign wbits      = i_req.wdata[PINS-1:0] & acc_mask;
  assign cfg_hit    = (i_req.addr[ADDR_W-1:7] == CFG_PAGE);
  assign cfg_idx    = i_req.addr[6:2];
  assign cap_clr_wr = i_req.wr && (i_req.addr == OFS_CAPTURE);

  // ****************************************************************
  // Per-pin pad, sense and capture logic
  // ****************************************************************
  for (genvar p = 0; p < PINS; p++)
  begin : g_pin
    logic rearmed;
    logic clr_ok;

    // Buffer is on when configured or when a peripheral asks for it
    assign in_en[p] = ~cfg_q[p].in_disc | (i_periph_own[p] & i_periph_in_req[p]);
    // Gating before the first stage makes a disconnected pin read zero
    assign samp1_d[p] = i_pad_in[p] & in_en[p];

    assign raw[p] = in_en[p] &&
                    (((cfg_q[p].sense == SENSE_HIGH) && in_q[p]) ||
                     ((cfg_q[p].sense == SENSE_LOW) && !in_q[p]));

    // Rest counter starts full, so a level already present hits at once
    assign rearmed    = (rest_q[p] == REARM_CYCLES);
    assign rest_d[p]  = raw[p] ? 2'h0 : (rearmed ? rest_q[p] : rest_q[p] + 2'h1);
    assign hit_d[p]   = raw[p] && (hit_q[p] || rearmed);

    // Clear needs a written one, access rights and a low hit; a new rise wins
    assign clr_ok     = cap_clr_wr && wbits[p] && !hit_q[p];
    assign flag_d[p]  = (hit_d[p] && !hit_q[p]) || (flag_q[p] && !clr_ok);

    // Peripheral ownership replaces the port's own output and direction
    assign pad_d.out[p]     = i_periph_own[p] ? i_periph_out[p] : out_d[p];
    assign pad_d.oe[p]      = i_periph_own[p] ? i_periph_oe[p]  : dir_d[p];
    assign pad_d.pull_up[p] = (cfg_d[p].pull == PULL_UP);
    assign pad_d.pull_dn[p] = (cfg_d[p].pull == PULL_DOWN);
    assign pad_d.in_en[p]   = ~cfg_d[p].in_disc | (i_periph_own[p] & i_periph_in_req[p]);
    assign drive_d[3*p +: 3] = cfg_d[p].drive;
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb
  begin
    out_d    = out_q;
    dir_d    = dir_q;
    src_ns_d = src_ns_q;
    src_s_d  = src_s_q;
    for (int k = 0; k < PINS; k++)
    begin
      cfg_d[k] = cfg_q[k];
    end
    // Dropped writes simply leave state alone; there is no error path
    if (i_req.wr)
    begin
      case (i_req.addr)
        OFS_OUT:        out_d    = (out_q & ~acc_mask) | wbits;
        OFS_OUTSET:     out_d    = out_q | wbits;
        OFS_OUTCLR:     out_d    = out_q & ~wbits;
        OFS_DIR:        dir_d    = (dir_q & ~acc_mask) | wbits;
        OFS_DIRSET:     dir_d    = dir_q | wbits;
        OFS_DIRCLR:     dir_d    = dir_q & ~wbits;
        OFS_HITSRC:     src_ns_d = i_req.wdata[0];
        OFS_HITSRC_SEC:
        begin
          if (i_req.secure)
          begin
            src_s_d = i_req.wdata[0];
          end
        end
        default:
        begin
          if (cfg_hit && acc_mask[cfg_idx])
          begin
            dir_d[cfg_idx]         = i_req.wdata[CFG_DIR_BIT];
            cfg_d[cfg_idx].in_disc = i_req.wdata[CFG_INDISC_BIT];
            cfg_d[cfg_idx].pull    = i_req.wdata[CFG_PULL_LSB +: 2];
            cfg_d[cfg_idx].drive   = i_req.wdata[CFG_DRIVE_LSB +: 3];
            cfg_d[cfg_idx].sense   = i_req.wdata[CFG_SENSE_LSB +: 2];
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_comb
  begin
    rdata_d = '0;
    if (i_req.rd)
    begin
      case (i_req.addr)
        OFS_OUT, OFS_OUTSET, OFS_OUTCLR: rdata_d[PINS-1:0] = out_q & acc_mask;
        OFS_IN:                          rdata_d[PINS-1:0] = in_q & acc_mask;
        OFS_DIR, OFS_DIRSET, OFS_DIRCLR: rdata_d[PINS-1:0] = dir_q & acc_mask;
        OFS_CAPTURE:                     rdata_d[PINS-1:0] = flag_q & acc_mask;
        OFS_HITSRC:                      rdata_d[0]        = src_ns_q;
        OFS_HITSRC_SEC:                  rdata_d[0]        = src_s_q & i_req.secure;
        default:
        begin
          // Unmapped offsets, and secure pins' pad_config on non-secure reads, read as zero
          if (cfg_hit && acc_mask[cfg_idx])
          begin
            rdata_d[CFG_DIR_BIT]          = dir_q[cfg_idx];
            rdata_d[CFG_INDISC_BIT]       = cfg_q[cfg_idx].in_disc;
            rdata_d[CFG_PULL_LSB +: 2]    = cfg_q[cfg_idx].pull;
            rdata_d[CFG_DRIVE_LSB +: 3]   = cfg_q[cfg_idx].drive;
            rdata_d[CFG_SENSE_LSB +: 2]   = cfg_q[cfg_idx].sense;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Port hit routing
  // ****************************************************************
  // Nothing here is gated by a power state, so sensing and wake keep running
  always_comb
  begin
    // A clear write pulls captured_hit low for one cycle; flags still set
    // afterwards then give a clean new rising edge
    cap_ns_d = |(flag_d & ~i_pad_security_map) && !cap_clr_wr;
    cap_s_d  = |(flag_d & i_pad_security_map) && !cap_clr_wr;
    hit_ns_d = src_ns_q ? cap_ns_d : |(hit_d & ~i_pad_security_map);
    hit_s_d  = src_s_q  ? cap_s_d  : |(hit_d & i_pad_security_map);
    wake_d   = hit_ns_d || hit_s_d;
  end

  // ****************************************************************
  // Flip-flops
  // ****************************************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      out_q    <= PORT_RESET[PINS-1:0];
      dir_q    <= PORT_RESET[PINS-1:0];
      flag_q   <= PORT_RESET[PINS-1:0];
      hit_q    <= '0;
      samp1_q  <= '0;
      in_q     <= '0;
      src_ns_q <= HITSRC_RESET;
      src_s_q  <= HITSRC_RESET;
      cap_ns_q <= 1'b0;
      cap_s_q  <= 1'b0;
      hit_ns_q <= 1'b0;
      hit_s_q  <= 1'b0;
      wake_q   <= 1'b0;
      rdata_q  <= '0;
      pad_q    <= '{out: '0, oe: '0, pull_up: '0, pull_dn: '0, in_en: '0};
      drive_q  <= '0;
      for (int k = 0; k < PINS; k++)
      begin
        cfg_q[k]  <= CFG_RESET;
        rest_q[k] <= REARM_CYCLES;
      end
    end
    else
    begin
      out_q    <= out_d;
      dir_q    <= dir_d;
      flag_q   <= flag_d;
      hit_q    <= hit_d;
      samp1_q  <= samp1_d;
      in_q     <= samp1_q;
      src_ns_q <= src_ns_d;
      src_s_q  <= src_s_d;
      cap_ns_q <= cap_ns_d;
      cap_s_q  <= cap_s_d;
      hit_ns_q <= hit_ns_d;
      hit_s_q  <= hit_s_d;
      wake_q   <= wake_d;
      rdata_q  <= rdata_d;
      pad_q    <= pad_d;
      drive_q  <= drive_d;
      for (int k = 0; k < PINS; k++)
      begin
        cfg_q[k]  <= cfg_d[k];
        rest_q[k] <= rest_d[k];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_rdata              = rdata_q;
  assign o_pad_ctrl           = pad_q;
  assign o_pad_drive          = drive_q;
  assign o_periph_in          = in_q;
  assign o_level_hit          = hit_q;
  assign o_nonsecure_port_hit = hit_ns_q;
  assign o_secure_port_hit    = hit_s_q;
  assign o_captured_hit_ns    = cap_ns_q;
  assign o_captured_hit_s     = cap_s_q;
  assign o_wake               = wake_q;

endmodule

/* File: verilog/gpio_sense_pkg.sv */
// Constants, field layouts and carrier types of the sensing GPIO port
package gpio_sense_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_PINS = 32;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_OUT         = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_OUTSET      = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_OUTCLR      = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_IN          = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_DIR         = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_DIRSET      = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_DIRCLR      = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE     = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_HITSRC      = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_HITSRC_SEC  = 12'h028;
  // pad_config[n] sits at 0x200 + 4*n: address bits 11:7 equal this page
  localparam logic [4:0]        CFG_PAGE        = 5'h04;

  // ****************************************************************
  // pad_config field positions and encodings
  // ****************************************************************
  localparam int CFG_DIR_BIT    = 0;
  localparam int CFG_INDISC_BIT = 1;
  localparam int CFG_PULL_LSB   = 2;
  localparam int CFG_DRIVE_LSB  = 8;
  localparam int CFG_SENSE_LSB  = 16;

  localparam logic [1:0] PULL_DOWN  = 2'h1;
  localparam logic [1:0] PULL_UP    = 2'h3;
  localparam logic [1:0] SENSE_HIGH = 2'h2;
  localparam logic [1:0] SENSE_LOW  = 2'h3;

  // Cycles off the sense level needed on the pad before a pin may hit again
  localparam logic [1:0] REARM_CYCLES = 2'h3;

  typedef struct packed {
    logic [1:0] sense;
    logic [2:0] drive;
    logic [1:0] pull;
    logic       in_disc;
  } pad_cfg_t;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam pad_cfg_t          CFG_RESET    = '{sense: 2'h0, drive: 3'h0, pull: 2'h0, in_disc: 1'b1};
  localparam logic [DATA_W-1:0] PORT_RESET   = 32'h00000000;
  localparam logic              HITSRC_RESET = 1'b0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic              secure;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pull_up;
    logic [NUM_PINS-1:0] pull_dn;
    logic [NUM_PINS-1:0] in_en;
  } pad_ctrl_t;

endpackage

/* File: verif/gpio_sense_port_properties.sv */
// Port-level assertions for the sensing GPIO port
`timescale 1ns/1ns
module gpio_sense_port_properties
  import gpio_sense_pkg::*;
#(
  parameter int PINS = NUM_PINS
)
(
  input wire logic              i_ref_clk,
  input wire logic              i_srst,
  input wire reg_req_t          i_req,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [PINS-1:0]   i_pad_security_map,
  input wire logic [PINS-1:0]   o_periph_in,
  input wire logic [PINS-1:0]   o_level_hit,
  input wire logic              o_nonsecure_port_hit,
  input wire logic              o_secure_port_hit,
  input wire logic              o_captured_hit_ns,
  input wire logic              o_wake
);
  // ****************************************************************
  // Shadow of the routing bit; the source check waits for quiet so a write never races it
  // ****************************************************************
  logic       mode_q;
  logic       mode_d;
  logic [1:0] quiet_q;
  logic [1:0] quiet_d;
  logic       cap_wr;
  always_comb
  begin
    cap_wr  = i_req.wr && (i_req.addr == OFS_CAPTURE);
    mode_d  = (i_req.wr && i_req.addr == OFS_HITSRC) ? i_req.wdata[0] : mode_q;
    quiet_d = i_req.wr ? 2'h0 : quiet_q + {1'b0, quiet_q != 2'h3};
  end
  always_ff @(posedge i_ref_clk)
  begin
    mode_q  <= i_srst ? HITSRC_RESET : mode_d;
    quiet_q <= i_srst ? 2'h0 : quiet_d;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_clear_held;
    cap_wr && o_captured_hit_ns && |(o_level_hit & ~i_pad_security_map);
  endsequence
  sequence s_low_pulse;
    !o_captured_hit_ns ##1 o_captured_hit_ns;
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_in_read_sec: assert property (
    i_req.rd && i_req.secure && i_req.addr == OFS_IN |=> o_rdata == $past(o_periph_in))
    else $error("secure input read wrong");
  a_in_read_ns: assert property (
    i_req.rd && !i_req.secure && i_req.addr == OFS_IN |=> o_rdata == $past(o_periph_in & ~i_pad_security_map))
    else $error("non-secure input read shows secure pins");
  a_modesec_hidden: assert property (
    i_req.rd && !i_req.secure && i_req.addr == OFS_HITSRC_SEC |=> o_rdata == '0)
    else $error("secure select visible to non-secure read");
  a_wake_or: assert property (
    o_wake == (o_nonsecure_port_hit | o_secure_port_hit))
    else $error("wake differs from port hits");
  a_rise_capture: assert property (
    |(o_level_hit & ~$past(o_level_hit) & ~i_pad_security_map) && !$past(cap_wr) |-> o_captured_hit_ns)
    else $error("hit rise not captured");
  a_flag_sticky: assert property (
    o_captured_hit_ns && !cap_wr |=> o_captured_hit_ns)
    else $error("capture lost without clear");
  a_clear_pulse: assert property (
    s_clear_held |=> s_low_pulse)
    else $error("no fresh rise after partial clear");
  a_ns_source: assert property (
    quiet_q == 2'h3 |-> o_nonsecure_port_hit == (mode_q ? o_captured_hit_ns : |(o_level_hit & ~i_pad_security_map)))
    else $error("non-secure port hit source wrong");
endmodule

/* File: verif/gpio_pad_model.sv */
// Behavioural pad circuitry facing the sensing GPIO port
`timescale 1ns/1ns
module gpio_pad_model
  import gpio_sense_pkg::*;
(
  input  wire logic                i_ref_clk,
  input  wire logic                i_srst,
  input  wire pad_ctrl_t           i_pad_ctrl,
  input  wire logic [NUM_PINS-1:0] i_ext_en,
  input  wire logic [NUM_PINS-1:0] i_ext_lvl,
  output logic      [NUM_PINS-1:0] o_pad
);
  // Undriven, unpulled pads wander every cycle so nothing leans on a stale level
  logic [NUM_PINS-1:0] float_q;
  always_comb
  begin
    o_pad = (i_pad_ctrl.oe & i_pad_ctrl.out) | (~i_pad_ctrl.oe & i_ext_en & i_ext_lvl)
          | (~i_pad_ctrl.oe & ~i_ext_en & (i_pad_ctrl.pull_up | (~i_pad_ctrl.pull_dn & float_q)));
  end
  always_ff @(posedge i_ref_clk)
  begin
    float_q <= i_srst ? 32'h55555555 : ~float_q;
  end
endmodule

/* File: verif/gpio_sense_port_bench.sv */
// Self-checking bench for the sensing GPIO port
`timescale 1ns/1ns
module gpio_sense_port_bench;
  import gpio_sense_pkg::*;
  logic              i_ref_clk = 1'b0;
  logic              i_srst = 1'b1;
  reg_req_t          i_req = '0;
  logic [31:0]       map = 32'h00000020;
  logic [31:0]       own = '0;
  logic [31:0]       ext_en = 32'h00000028;
  logic [31:0]       ext_lvl = 32'h00000008;
  logic [31:0]       pad;
  logic [31:0]       rdata;
  logic [31:0]       rnd = 32'h0000004c;
  logic [31:0]       r2;
  logic [31:0]       exp_out;
  logic [31:0]       periph_in;
  logic [31:0]       hit;
  pad_ctrl_t         ctrl;
  logic [95:0]       drive;
  logic              ns_hit;
  logic              s_hit;
  logic              cap_ns;
  logic              cap_s;
  logic              wake;
  int                miscompares = 0;
  int                checks_done = 0;
  always #20 i_ref_clk = ~i_ref_clk;
  gpio_sense_port dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req(i_req), .o_rdata(rdata), .i_pad_in(pad),
    .i_pad_security_map(map), .i_periph_own(own), .i_periph_out(own), .i_periph_oe(own), .i_periph_in_req(own),
    .o_pad_ctrl(ctrl), .o_pad_drive(drive), .o_periph_in(periph_in), .o_level_hit(hit), .o_nonsecure_port_hit(ns_hit),
    .o_secure_port_hit(s_hit), .o_captured_hit_ns(cap_ns), .o_captured_hit_s(cap_s), .o_wake(wake));
  gpio_pad_model u_pads (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_pad_ctrl(ctrl), .i_ext_en(ext_en),
    .i_ext_lvl(ext_lvl), .o_pad(pad));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] ns_view(input logic [31:0] d);
    return d & ~map;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(input logic s, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_req <= '{1'b1, 1'b0, s, a, d};
    @(posedge i_ref_clk);
    i_req <= '0;
  endtask
  task automatic rdc(input logic s, input logic [11:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_req <= '{1'b0, 1'b1, s, a, 32'h0};
    @(posedge i_ref_clk);
    i_req <= '0;
    #1;
    chk(rdata, e);
  endtask
  task automatic lvl(input int p, input logic v);
    @(posedge i_ref_clk);
    ext_lvl[p] <= v;
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    wt(1);
    chk(ctrl.in_en, 32'h0);
    rdc(1'b1, 12'h27c, 32'h00000002);
    wr(1'b1, 12'h100, 32'hffffffff);
    rdc(1'b1, 12'h100, 32'h0);
    rdc(1'b1, OFS_IN, 32'h0);
    wr(1'b1, 12'h20c, 32'h0);
    wt(3);
    rdc(1'b0, OFS_IN, 32'h00000008);
    lvl(3, 1'b0);
    wt(1);
    chk(periph_in[3], 1'b1);
    wt(1);
    chk(periph_in[3], 1'b0);
    $display("input path test done");
    wr(1'b0, 12'h20c, 32'h00020000);
    lvl(3, 1'b1);
    wt(2);
    chk(hit[3], 1'b0);
    wt(1);
    chk({hit[3], cap_ns, ns_hit, wake}, 4'hf);
    wr(1'b0, OFS_CAPTURE, 32'h8);
    rdc(1'b0, OFS_CAPTURE, 32'h8);
    lvl(3, 1'b0);
    wt(4);
    chk({hit[3], cap_ns, ns_hit}, 3'h2);
    rdc(1'b0, OFS_CAPTURE, 32'h8);
    wr(1'b0, OFS_CAPTURE, 32'h8);
    wt(1);
    chk(cap_ns, 1'b0);
    lvl(3, 1'b1);
    wt(5);
    lvl(3, 1'b0);
    wt(1);
    lvl(3, 1'b1);
    wt(6);
    chk(hit[3], 1'b0);
    lvl(3, 1'b0);
    wt(4);
    lvl(3, 1'b1);
    wt(4);
    chk(hit[3], 1'b1);
    $display("sense test done");
    wr(1'b0, OFS_HITSRC, 32'h1);
    rdc(1'b0, OFS_HITSRC, 32'h1);
    lvl(3, 1'b0);
    wt(4);
    chk({hit[3], ns_hit}, 2'h1);
    wr(1'b1, OFS_CAPTURE, 32'hffffffff);
    wt(2);
    chk({cap_ns, ns_hit}, 2'h0);
    wr(1'b0, OFS_HITSRC, 32'h0);
    wr(1'b1, OFS_OUT, 32'h20);
    wr(1'b0, OFS_OUTCLR, 32'hffffffff);
    rdc(1'b1, OFS_OUT, 32'h20);
    rdc(1'b0, OFS_OUT, 32'h0);
    wr(1'b0, OFS_HITSRC_SEC, 32'h1);
    rdc(1'b1, OFS_HITSRC_SEC, 32'h0);
    wr(1'b1, OFS_HITSRC_SEC, 32'h1);
    rdc(1'b0, OFS_HITSRC_SEC, 32'h0);
    rdc(1'b1, OFS_HITSRC_SEC, 32'h1);
    lvl(5, 1'b1);
    wr(1'b0, 12'h214, 32'h00020000);
    rdc(1'b0, 12'h214, 32'h0);
    rdc(1'b1, 12'h214, 32'h00000002);
    wr(1'b1, 12'h214, 32'h00020000);
    wt(6);
    chk({hit[5], cap_s, s_hit, cap_ns, ns_hit}, 5'h1c);
    rdc(1'b0, OFS_CAPTURE, 32'h0);
    wr(1'b0, OFS_CAPTURE, 32'hffffffff);
    rdc(1'b1, OFS_CAPTURE, 32'h20);
    lvl(5, 1'b0);
    wt(4);
    chk({hit[5], s_hit}, 2'h1);
    wr(1'b1, OFS_CAPTURE, 32'hffffffff);
    $display("security test done");
    // Pull-up first so the pin already reads high when low sensing is armed
    wr(1'b0, 12'h208, 32'h0000050c);
    wt(1);
    chk({drive[8:6], ctrl.pull_up[2], ctrl.pull_dn[2]}, 5'h16);
    wt(3);
    chk(periph_in[2], 1'b1);
    wr(1'b0, 12'h208, 32'h00030304);
    wt(1);
    chk({drive[8:6], ctrl.pull_up[2], ctrl.pull_dn[2]}, 5'h0d);
    wt(2);
    chk({hit[2], cap_ns, ns_hit}, 3'h7);
    $display("pull and low sense test done");
    @(posedge i_ref_clk);
    own[7] <= 1'b1;
    wt(5);
    chk({ctrl.out[7], ctrl.oe[7], ctrl.in_en[7], periph_in[7]}, 4'hf);
    for (int i = 0; i < 12; i++)
    begin
      rnd = xs(rnd);
      r2 = xs(~rnd);
      exp_out = rnd | ns_view(r2);
      wr(1'b1, OFS_OUT, rnd);
      wr(1'b0, OFS_OUTSET, r2);
      rdc(1'b1, OFS_OUTCLR, exp_out);
      rdc(1'b0, OFS_OUT, ns_view(exp_out));
    end
    $display("override and random test done");
    summarize();
  end
  initial
  begin
    repeat (5000) @(posedge i_ref_clk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
bind gpio_sense_port gpio_sense_port_properties #(.PINS(PINS)) u_props (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .i_req(i_req), .o_rdata(o_rdata), .i_pad_security_map(i_pad_security_map), .o_periph_in(o_periph_in),
  .o_level_hit(o_level_hit), .o_nonsecure_port_hit(o_nonsecure_port_hit), .o_secure_port_hit(o_secure_port_hit),
  .o_captured_hit_ns(o_captured_hit_ns), .o_wake(o_wake));
